// *** core/atptd_pkg.sv ***
package atptd_pkg;
    // Command block byte positions
    localparam int CB_BYTES = 16;
    localparam int CB_SUBCMD_IDX = 1;
    localparam int CB_ACTION_IDX = 2;
    localparam int CB_MASK_IDX = 3;
    localparam int CB_BLKCNT_IDX = 4;
    localparam int CB_WDATA_IDX = 5;
    localparam int CB_DEVREG_IDX = 11;
    localparam int CB_DEVSEL_BIT = 4;
    localparam int ACT_RDBACK_BIT = 0;
    localparam int ACT_OVERRIDE_BIT = 5;
    localparam logic [7:0] SUBCMD_PASSTHRU = 8'h24;
    localparam int TF_REGS = 8;
    localparam logic [31:0] RDBACK_LEN = 32'h0000_0008;
    localparam logic [7:0] RDBACK_ZERO = 8'h00;
    localparam logic [8:0] BLK_ZERO_MEANS = 9'h100;
    // Taskfile register addresses, indexed by select bit
    localparam logic [9:0] TF_ADDR0 = 10'h3F6;
    localparam logic [9:0] TF_ADDR_BASE = 10'h1F0;
    // Wishbone register map (byte addresses)
    localparam logic [7:0] WB_CTRL = 8'h00;
    localparam logic [7:0] WB_STATUS = 8'h04;
    localparam logic [7:0] WB_RDBACK_LO = 8'h08;
    localparam logic [7:0] WB_RDBACK_HI = 8'h0C;
    localparam logic [7:0] WB_BLKSIZE = 8'h10;
    localparam int CTRL_LUN_DEV_BIT = 0;
    localparam int CTRL_CLR_BIT = 1;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_FAIL_BIT = 2;
    localparam int ST_NOTPT_BIT = 3;

    typedef struct packed {
        logic [9:0] addr;
        logic write;
        logic [7:0] wdata;
    } atptd_tf_req_t;

    typedef struct packed {
        logic [7:0] adr;
        logic [31:0] dat;
        logic we;
        logic [3:0] sel;
        logic cyc;
        logic stb;
    } atptd_wb_req_t;
endpackage

// *** core/atptd_decoder.sv ***
// Notes on behaviour
// - With the override flag the drive select bit comes from byte 11 bit 4, else the LUN value.
// - The select mask in byte 3 decides which taskfile accesses happen.
// - Mask bits 0..7 map to device control, features, count, number, cyl lo, cyl hi, dev, command.
// - Selected accesses run one after another from bit 0 up to bit 7.
// - Readback is always exactly eight bytes.
// - Unselected registers read back as zero.
// - Readback bytes 3..7 hold sector number, cyl lo, cyl hi, device/head and status.
// - Byte 4 is the largest block size in 512-byte units.
// - Only 0,1,2,4,8,16,32,64,128 are legal and 0 means 256 sectors.
// - An illegal block count ends the command with command-failed status.
// - Write values come from bytes 5 through 12.
// - Write bytes for unselected registers are ignored.
// - Byte 5+n is written to the register of select bit n.
`timescale 1ns/1ps
module atptd_decoder
    import atptd_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Command block from the bulk-only front end
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [CB_BYTES*8-1:0] cmd_block,
    input wire logic [31:0] cmd_xfer_len,
    // Completion to the front end
    output logic cmd_done,
    output logic cmd_failed,
    output logic data_phase_start,
    output logic [8:0] data_block_sectors,
    output logic [63:0] rdback_data,
    output logic rdback_valid,
    // Taskfile access port towards the drive
    output atptd_pkg::atptd_tf_req_t tf_req,
    output logic tf_req_valid,
    input wire logic tf_ack,
    input wire logic [7:0] tf_rdata,
    // Wishbone slave
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    typedef enum logic [2:0] {S_IDLE, S_CHECK, S_ACCESS, S_WAIT, S_FINISH} atptd_state_t;

    atptd_state_t state_reg;
    logic [7:0] cb_reg [CB_BYTES];
    logic [7:0] mask_reg;
    logic [2:0] idx_reg;
    logic [7:0] rdback_reg [TF_REGS];
    logic readback_mode_reg;
    logic fail_reg;
    logic notpt_reg;
    logic done_reg;
    logic lun_dev_reg;
    logic [8:0] blk_sectors_reg;
    logic blk_legal;
    logic [8:0] blk_sectors;
    logic [7:0] wr_byte;
    logic [9:0] cur_addr;
    // Qualifiers shared by the sequencer and the status logic
    logic cmd_take;
    logic finishing;
    logic busy;
    logic fail_any;
    logic len_bad;
    logic ctrl_write;
    logic [31:0] wb_dat_next;

    wire logic [7:0] blk_byte = cb_reg[CB_BLKCNT_IDX];
    wire logic [7:0] act_byte = cb_reg[CB_ACTION_IDX];
    wire logic wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_comb begin
        cmd_take = (state_reg == S_IDLE) && cmd_valid;
        finishing = (state_reg == S_FINISH);
        busy = (state_reg != S_IDLE);
        fail_any = fail_reg || notpt_reg;
        ctrl_write = wb_req && wb_we_i && (wb_adr_i == WB_CTRL) && wb_sel_i[0];
        // Length is judged only for readback-only blocks; a data command sets its own
        len_bad = act_byte[ACT_RDBACK_BIT] && (cmd_xfer_len != RDBACK_LEN);
    end

    // Power of two or zero are legal; zero stands for 256
    always_comb begin
        blk_legal = (blk_byte & (blk_byte - 8'h01)) == 8'h00;
        blk_sectors = (blk_byte == 8'h00) ? BLK_ZERO_MEANS : {1'b0, blk_byte};
    end

    // Addresses follow select-bit order; bit 0 is the control block register
    always_comb begin
        cur_addr = (idx_reg == 3'h0) ? TF_ADDR0 : (TF_ADDR_BASE | {7'h00, idx_reg});
        wr_byte = cb_reg[CB_WDATA_IDX + int'(idx_reg)];
        if ((idx_reg == 3'(CB_DEVREG_IDX - CB_WDATA_IDX)) && !act_byte[ACT_OVERRIDE_BIT]) begin
            wr_byte[CB_DEVSEL_BIT] = lun_dev_reg;
        end
    end

    assign cmd_ready = (state_reg == S_IDLE);
    assign tf_req_valid = (state_reg == S_WAIT);

    // Per-command fields latched while the block is checked
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            mask_reg <= 8'h00;
            readback_mode_reg <= 1'b0;
        end else if (state_reg == S_CHECK) begin
            mask_reg <= cb_reg[CB_MASK_IDX];
            readback_mode_reg <= act_byte[ACT_RDBACK_BIT];
        end
    end

    // Index walk: one step per skipped bit or acknowledged access; it stops at
    // bit 7 so a full mask never wraps back to bit 0
    always_ff @(posedge core_clk) begin
        if (!reset_n || state_reg == S_CHECK) begin
            idx_reg <= 3'h0;
        end else if (state_reg == S_ACCESS && !mask_reg[idx_reg] && idx_reg != 3'h7) begin
            idx_reg <= idx_reg + 3'h1;
        end else if (state_reg == S_WAIT && tf_ack && idx_reg != 3'h7) begin
            idx_reg <= idx_reg + 3'h1;
        end
    end

    // Request word loads only for selected bits and holds through the wait,
    // since the drive may take any number of cycles to acknowledge
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            tf_req <= '0;
        end else if (state_reg == S_ACCESS && mask_reg[idx_reg]) begin
            tf_req.addr <= cur_addr;
            tf_req.write <= !readback_mode_reg;
            tf_req.wdata <= wr_byte;
        end
    end

    // Sequencer: check, then an access and a wait per selected bit, then finish;
    // unselected bits cost one cycle each
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_reg <= S_IDLE;
        end else begin
            unique case (state_reg)
                S_IDLE: begin
                    if (cmd_take) begin
                        state_reg <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    // Nothing touches the drive for foreign or malformed blocks
                    if (cb_reg[CB_SUBCMD_IDX] != SUBCMD_PASSTHRU || !blk_legal
                        || len_bad) begin
                        state_reg <= S_FINISH;
                    end else begin
                        state_reg <= S_ACCESS;
                    end
                end
                S_ACCESS: begin
                    if (mask_reg[idx_reg]) begin
                        state_reg <= S_WAIT;
                    end else if (idx_reg == 3'h7) begin
                        state_reg <= S_FINISH;
                    end
                end
                S_WAIT: begin
                    if (tf_ack) begin
                        state_reg <= (idx_reg == 3'h7) ? S_FINISH : S_ACCESS;
                    end
                end
                S_FINISH: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // Command block capture; the copy is frozen until the next take, so every
    // later block field comes from these flops; only cmd_xfer_len is read live, in the check state
    generate
        for (genvar i = 0; i < CB_BYTES; i++) begin : g_cb
            always_ff @(posedge core_clk) begin
                if (!reset_n) begin
                    cb_reg[i] <= 8'h00;
                end else if (cmd_take) begin
                    cb_reg[i] <= cmd_block[i*8 +: 8];
                end
            end
        end
    endgenerate

    // Readback bytes: zeroed per command, filled only for selected reads
    generate
        for (genvar r = 0; r < TF_REGS; r++) begin : g_rb
            always_ff @(posedge core_clk) begin
                if (!reset_n || state_reg == S_CHECK) begin
                    rdback_reg[r] <= RDBACK_ZERO;
                end else if (state_reg == S_WAIT && tf_ack && readback_mode_reg
                             && idx_reg == 3'(r)) begin
                    rdback_reg[r] <= tf_rdata;
                end
            end
            assign rdback_data[r*8 +: 8] = rdback_reg[r];
        end
    endgenerate

    // Completion pulses, one cycle each, in the cycle after the finish state; done always, the others by verdict and mode
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            cmd_done <= 1'b0;
            cmd_failed <= 1'b0;
            rdback_valid <= 1'b0;
            data_phase_start <= 1'b0;
        end else begin
            cmd_done <= finishing;
            cmd_failed <= finishing && fail_any;
            rdback_valid <= finishing && readback_mode_reg && !fail_any;
            // A readback with the wrong length is refused rather than truncated
            data_phase_start <= finishing && !readback_mode_reg && !fail_any;
        end
    end

    // Verdict flags stand until the next block is checked, so software may read
    // them long after the completion pulse
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            fail_reg <= 1'b0;
            notpt_reg <= 1'b0;
        end else if (state_reg == S_CHECK) begin
            notpt_reg <= (cb_reg[CB_SUBCMD_IDX] != SUBCMD_PASSTHRU);
            fail_reg <= !blk_legal || len_bad;
        end
    end

    // Block size is decoded once per command and held for the data phase
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            blk_sectors_reg <= 9'h000;
            data_block_sectors <= 9'h000;
        end else if (state_reg == S_CHECK) begin
            blk_sectors_reg <= blk_sectors;
            data_block_sectors <= blk_sectors;
        end
    end

    // Sticky done; a finish in the same cycle as a software clear wins, so a
    // completion is never lost to a late clear
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            done_reg <= 1'b0;
        end else if (finishing) begin
            done_reg <= 1'b1;
        end else if (ctrl_write && wb_dat_i[CTRL_CLR_BIT]) begin
            done_reg <= 1'b0;
        end
    end

    // Wishbone slave: ack one cycle after the request, high for exactly one cycle
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // Unit select bit used for the device register unless the block overrides it
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            lun_dev_reg <= 1'b0;
        end else if (ctrl_write) begin
            lun_dev_reg <= wb_dat_i[CTRL_LUN_DEV_BIT];
        end
    end

    // Read mux; unmapped offsets read as zero and writes to them are dropped,
    // so software probing the map never disturbs a running command
    always_comb begin
        unique case (wb_adr_i)
            WB_CTRL: wb_dat_next = {31'h0, lun_dev_reg};
            WB_STATUS: wb_dat_next = {28'h0, notpt_reg, fail_reg, done_reg,
                                      busy};
            WB_RDBACK_LO: wb_dat_next = {rdback_reg[3], rdback_reg[2],
                                         rdback_reg[1], rdback_reg[0]};
            WB_RDBACK_HI: wb_dat_next = {rdback_reg[7], rdback_reg[6],
                                         rdback_reg[5], rdback_reg[4]};
            WB_BLKSIZE: wb_dat_next = {23'h0, blk_sectors_reg};
            default: wb_dat_next = 32'h0000_0000;
        endcase
    end

    // Read data is registered so that it stands with the ack
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            wb_dat_o <= wb_dat_next;
        end
    end
endmodule // atptd_decoder

// *** testbench/atptd_sva.sv ***
`timescale 1ns/1ps
module atptd_sva
    import atptd_pkg::*;
(
    // Clock and command side
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [127:0] cmd_block,
    input wire logic cmd_done,
    input wire logic cmd_failed,
    input wire logic [8:0] data_block_sectors,
    input wire logic [63:0] rdback_data,
    input wire logic rdback_valid,
    // Taskfile side
    input wire atptd_pkg::atptd_tf_req_t tf_req,
    input wire logic tf_req_valid,
    input wire logic tf_ack
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic [127:0] cb_q;
    logic [63:0] keep;
    logic [2:0] idx;
    logic [2:0] last_q;
    logic seen_q;
    logic [7:0] served_q;
    logic [2:0] nxt;
    wire take = cmd_valid && cmd_ready;
    wire bad = !$onehot0(cmd_block[39:32]);
    assign idx = (tf_req.addr == TF_ADDR0) ? 3'h0 : tf_req.addr[2:0];
    always_comb for (int i = 0; i < 8; i++) keep[8*i+:8] = {8{cb_q[24+i]}};
    always_ff @(posedge core_clk) if (take) cb_q <= cmd_block;
    always_ff @(posedge core_clk) if (tf_req_valid && tf_ack) last_q <= idx;
    // Expected register is the lowest selected bit not yet served in this command
    always_comb begin
        nxt = 3'h0;
        for (int i = 7; i >= 0; i--) if (cb_q[24 + i] && !served_q[i]) nxt = 3'(i);
    end
    // Order is judged only inside one command, so the first access is free
    always_ff @(posedge core_clk) begin
        if (!reset_n || take || cmd_done) begin
            seen_q <= 1'b0;
            served_q <= 8'h00;
        end else if (tf_req_valid && tf_ack) begin
            seen_q <= 1'b1;
            served_q[idx] <= 1'b1;
        end
    end
    a_addr_map: assert property (
        tf_req_valid |-> tf_req.addr == (nxt == 3'h0 ? TF_ADDR0 : TF_ADDR_BASE + 10'(nxt)))
        else $error("taskfile address off the map");
    a_order_up: assert property (
        tf_req_valid && seen_q |-> idx > last_q) else $error("access out of order");
    a_only_sel: assert property (
        tf_req_valid |-> cb_q[24 + idx]) else $error("unselected register accessed");
    a_wdata_src: assert property (
        tf_req_valid && tf_req.write |->
        ((tf_req.wdata ^ cb_q[40 + 8*idx +: 8]) & (idx == 6 ? 8'hEF : 8'hFF)) == 8'h00)
        else $error("write data from wrong byte");
    a_dev_override: assert property (
        tf_req_valid && tf_req.write && idx == 6 && cb_q[21] |-> tf_req.wdata[4] == cb_q[92])
        else $error("select bit not taken from command");
    a_blk_size: assert property (
        take && !bad && cmd_block[15:8] == SUBCMD_PASSTHRU && !cmd_block[16] |-> ##2
        data_block_sectors == (cb_q[39:32] == 8'h00 ? BLK_ZERO_MEANS : {1'b0, cb_q[39:32]}))
        else $error("block size wrong");
    a_bad_fail: assert property (
        take && bad |-> ##[3:12] (cmd_done && cmd_failed)) else $error("illegal count not failed");
    a_bad_quiet: assert property (
        take && bad |=> (!tf_req_valid) [*5]) else $error("access on illegal count");
    a_rdback_zero: assert property (
        rdback_valid |-> (rdback_data & ~keep) == 64'h0) else $error("unselected byte not zero");
    c_readback: cover property (rdback_valid);
    c_failed: cover property (cmd_failed);
    c_write: cover property (tf_req_valid && tf_ack && tf_req.write);
endmodule // atptd_sva

// *** testbench/atptd_drive_model.sv ***
`timescale 1ns/1ps
module atptd_drive_model
    import atptd_pkg::*;
(
    // Clock, reset and pace
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic slow,
    // Taskfile port
    input wire atptd_pkg::atptd_tf_req_t tf_req,
    input wire logic tf_req_valid,
    output logic tf_ack,
    output logic [7:0] tf_rdata
);
    logic [7:0] regs [8];
    logic [2:0] wait_q;
    logic [2:0] n;
    assign n = (tf_req.addr == TF_ADDR0) ? 3'h0 : tf_req.addr[2:0];
    always_ff @(posedge core_clk) begin
        tf_ack <= 1'b0;
        // Data lines toggle when idle so a late sample never looks valid
        tf_rdata <= ~tf_rdata;
        if (!reset_n) begin
            wait_q <= 3'h0;
            tf_rdata <= 8'h5A;
            for (int i = 0; i < 8; i++) regs[i] <= 8'hA0 + 8'(i);
        end else if (tf_req_valid && !tf_ack) begin
            wait_q <= wait_q + 3'h1;
            if (wait_q == (slow ? 3'h5 : 3'h0)) begin
                wait_q <= 3'h0;
                tf_ack <= 1'b1;
                tf_rdata <= regs[n];
                if (tf_req.write) regs[n] <= tf_req.wdata;
            end
        end
    end
endmodule // atptd_drive_model

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb;
    import atptd_pkg::*;
    logic core_clk, reset_n, cmd_valid, wb_we, wb_cyc, wb_stb, slow, r_fail, r_phase, r_rv;
    logic cmd_ready, cmd_done, cmd_failed, phase, rv, tf_req_valid, tf_ack, wb_ack_o;
    logic [127:0] cmd_block;
    logic [31:0] cmd_xfer_len, wb_dat, rd, wb_dat_o;
    logic [7:0] wb_adr, tf_rdata;
    logic [7:0] tfm [8];
    logic [3:0] wb_sel;
    logic [8:0] sectors, r_sec;
    logic [63:0] rdback_data, r_data;
    atptd_tf_req_t tf_req;
    int fail_count, cmp_count;
    atptd_decoder uut (.core_clk, .reset_n, .cmd_valid, .cmd_ready, .cmd_block, .cmd_xfer_len,
        .cmd_done, .cmd_failed, .data_phase_start(phase), .data_block_sectors(sectors),
        .rdback_data, .rdback_valid(rv), .tf_req, .tf_req_valid, .tf_ack, .tf_rdata,
        .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_we_i(wb_we), .wb_sel_i(wb_sel),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o, .wb_ack_o);
    atptd_drive_model drv (.core_clk, .reset_n, .slow, .tf_req, .tf_req_valid, .tf_ack,
        .tf_rdata);
    task automatic check(input string nm, input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic bound(input int n);
        if (n >= 200) begin
            fail_count++;
            complete_run();
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {1'b1, 1'b1, w, a, d};
        // Values read just after an edge are the ones the slave showed at it
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 200);
        rd = wb_dat_o;
        {wb_cyc, wb_stb} <= 2'b00;
        bound(n);
    endtask
    task automatic run_cmd(input logic [7:0] sub, act, mask, blk, input logic [63:0] wd,
        input logic [31:0] len);
        int n;
        n = 0;
        do @(negedge core_clk); while (cmd_ready !== 1'b1 && ++n < 200);
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_block <= {24'h0, wd, blk, mask, act, sub, 8'h00};
        cmd_xfer_len <= len;
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        do @(negedge core_clk); while (cmd_done !== 1'b1 && ++n < 200);
        {r_fail, r_phase, r_rv, r_data, r_sec} = {cmd_failed, phase, rv, rdback_data, sectors};
        bound(n);
    endtask
    function automatic logic [63:0] rb_exp(input logic [7:0] mask);
        for (int i = 0; i < 8; i++) rb_exp[8*i+:8] = mask[i] ? tfm[i] : 8'h00;
    endfunction
    task automatic do_write(input logic [7:0] act, mask, input logic [63:0] wd);
        run_cmd(SUBCMD_PASSTHRU, act, mask, 8'h08, wd, 32'h0000_0200);
        check("write fail", r_fail, 1'b0);
        check("data phase", r_phase, 1'b1);
        for (int i = 0; i < 8; i++) if (mask[i]) tfm[i] = wd[8*i+:8];
        // CTRL holds a one in the unit select bit from here on
        if (mask[6] && !act[5]) tfm[6][4] = 1'b1;
    endtask
    task automatic do_read(input logic [7:0] mask);
        run_cmd(SUBCMD_PASSTHRU, 8'h01, mask, 8'h00, ~64'h0, RDBACK_LEN);
        check("readback", r_data, rb_exp(mask));
        check("readback strobe", r_rv, 1'b1);
    endtask
    task automatic sc_regs();
        wb(1'b1, WB_CTRL, 32'h0000_0001);
        wb(1'b0, WB_CTRL, 32'h0);
        check("ctrl", rd[0], 1'b1);
        wb(1'b0, 8'h20, 32'h0);
        check("unmapped", rd, 32'h0);
    endtask
    task automatic sc_write_rb();
        do_write(8'h00, 8'hFF, 64'hEC_E0_5A_3C_22_11_03_0A);
        do_read(8'hFF);
        wb(1'b0, WB_RDBACK_HI, 32'h0);
        check("readback hi reg", rd, {tfm[7], tfm[6], tfm[5], tfm[4]});
        wb(1'b0, WB_BLKSIZE, 32'h0);
        check("block size reg", rd, 32'h0000_0100);
        slow <= 1'b1;
        do_read(8'hA5);
        slow <= 1'b0;
    endtask
    task automatic sc_override();
        do_write(8'h20, 8'h40, 64'hFF_A0_FF_FF_FF_FF_FF_FF);
        do_read(8'hFF);
    endtask
    task automatic sc_counts();
        logic [7:0] b;
        for (int i = 0; i < 11; i++) begin
            b = i == 0 ? 8'h00 : i < 9 ? 8'h01 << (i - 1) : i == 9 ? 8'h03 : 8'hFF;
            run_cmd(SUBCMD_PASSTHRU, 8'h00, i > 8 ? 8'hFF : 8'h00, b, 64'h0, 32'h200);
            check("count fail", r_fail, i > 8);
            check("count phase", r_phase, i < 9);
            if (i < 9) check("sectors", r_sec, b == 0 ? 9'h100 : {1'b0, b});
        end
        wb(1'b0, WB_STATUS, 32'h0);
        check("status fail", rd[ST_FAIL_BIT], 1'b1);
        do_read(8'hFF);
    endtask
    task automatic sc_refused();
        run_cmd(8'h25, 8'h00, 8'h00, 8'h01, 64'h0, 32'h200);
        check("subcode", r_fail, 1'b1);
        wb(1'b0, WB_STATUS, 32'h0);
        check("not passthru flag", rd[ST_NOTPT_BIT], 1'b1);
        run_cmd(SUBCMD_PASSTHRU, 8'h01, 8'hFF, 8'h01, 64'h0, 32'h9);
        check("readback length", r_fail, 1'b1);
        check("length strobe", r_rv, 1'b0);
        wb(1'b1, WB_CTRL, 32'h0000_0003);
        wb(1'b0, WB_STATUS, 32'h0);
        check("done cleared", rd[ST_DONE_BIT], 1'b0);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        {reset_n, cmd_valid, wb_cyc, wb_stb, wb_we, slow, cmd_block, cmd_xfer_len} = '0;
        {wb_adr, wb_dat, fail_count, cmp_count} = '0;
        wb_sel = 4'hF;
        for (int i = 0; i < 8; i++) tfm[i] = 8'hA0 + 8'(i);
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        sc_regs();
        sc_write_rb();
        sc_override();
        sc_counts();
        sc_refused();
        complete_run();
    end
endmodule // tb
bind atptd_decoder atptd_sva chk (.core_clk, .reset_n, .cmd_valid, .cmd_ready, .cmd_block,
    .cmd_done, .cmd_failed, .data_block_sectors, .rdback_data, .rdback_valid, .tf_req,
    .tf_req_valid, .tf_ack);
